// ==== core/gdfs_defs.vh ====
// gdfs_defs.vh: offsets, field positions, reset values and timing counts
`ifndef GDFS_DEFS_VH
`define GDFS_DEFS_VH

// register word index on the avalon bus (byte address bits 5:2)
`define GDFS_IDX_WARN     4'h1
`define GDFS_IDX_FAULT    4'h3
`define GDFS_IDX_CTRL     4'h9
`define GDFS_IDX_REG      4'hb
`define GDFS_IDX_MON      4'hf
`define GDFS_ADDR_W       6

// warning status word (index 1)
`define GDFS_W_OTW        0
`define GDFS_W_TEMP3      1
`define GDFS_W_TEMP2      2
`define GDFS_W_TEMP1      3
`define GDFS_W_OV         6
`define GDFS_W_UVFL       7
`define GDFS_W_TEMP4      8

// fault status word (index 3)
`define GDFS_F_PUMP_REL   0
`define GDFS_F_PUMP_ABS   1
`define GDFS_F_PUMP_UV    2
`define GDFS_F_LS_UV      4
`define GDFS_F_REG_UV     6
`define GDFS_F_OVERHEAT_SHUTDOWN       8
`define GDFS_F_WDOG       9
`define GDFS_F_LOCKOUT    10

// control word (index 9)
`define GDFS_C_CLR        1
`define GDFS_C_WATCHDOG_ENABLE_BIT      3
`define GDFS_C_WD_SEL_LO  5
`define GDFS_C_WD_SEL_HI  6
`define GDFS_C_UVLO_DIS   9
`define GDFS_CTRL_RST     11'h000
`define GDFS_CTRL_MASK    11'h26a

// regulator monitor word (index b)
`define GDFS_R_LVL_LO     0
`define GDFS_R_LVL_HI     1
`define GDFS_R_MON_DIS    2
`define GDFS_REG_RST      11'h000
`define GDFS_REG_MASK     11'h007

// timing: figures in ns, counts at 200 MHz
`define GDFS_CLK_NS       5
`define GDFS_PG_PULSE_NS  56000
`define GDFS_PG_CYC       (`GDFS_PG_PULSE_NS / `GDFS_CLK_NS)
`define GDFS_EN_LOW_NS    1000
`define GDFS_EN_LOW_CYC   ((`GDFS_EN_LOW_NS + `GDFS_CLK_NS - 1) / `GDFS_CLK_NS)
`define GDFS_CNT_W        24

`endif

// ==== core/gdfs_sync.v ====
// gdfs_sync.v: two flip-flop level synchroniser
`timescale 1ns/1ps
module gdfs_sync (
  core_clk,
  nrst,
  din,
  dout
);
  input  wire core_clk;
  input  wire nrst;
  input  wire din;
  output wire dout;

  reg meta_ff;
  reg sync_ff;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule // gdfs_sync

// ==== core/gdfs_timer.v ====
// gdfs_timer.v: retriggerable down counter, busy while nonzero
`timescale 1ns/1ps
`include "gdfs_defs.vh"
module gdfs_timer (
  core_clk,
  nrst,
  load,
  load_val,
  busy,
  done
);
  input  wire                   core_clk;
  input  wire                   nrst;
  input  wire                   load;
  input  wire [`GDFS_CNT_W-1:0] load_val;
  output wire                   busy;
  output reg                    done;

  reg [`GDFS_CNT_W-1:0] cnt_ff;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= {`GDFS_CNT_W{1'b0}};
      done   <= 1'b0;
    end else if (load) begin
      cnt_ff <= load_val;
      done   <= 1'b0;
    end else begin
      done   <= (cnt_ff == {{(`GDFS_CNT_W-1){1'b0}}, 1'b1});
      if (cnt_ff != {`GDFS_CNT_W{1'b0}})
        cnt_ff <= cnt_ff - {{(`GDFS_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign busy = (cnt_ff != {`GDFS_CNT_W{1'b0}});
endmodule // gdfs_timer

// ==== core/gdfs_top.v ====
// gdfs_top.v: fault and warning supervisor with avalon register slave
`timescale 1ns/1ps
`include "gdfs_defs.vh"
// Functional notes
// R1: supply low warning keeps running, asserts indicator, sets warning bit 7.
// R2: gate driver lockout stops driver, asserts indicator, sets fault bit 10.
// R3: lockout disable bit skips shutdown but still sets the status bit.
// R4: supply over warning keeps running, asserts indicator, sets warning bit 6.
// R5: pump relative and absolute overvoltage are faults at bits 0 and 1.
// R6: pump undervoltage stops driver, asserts indicator, sets fault bit 2.
// R7: low side supply undervoltage stops driver, sets fault bit 4.
// R8: pump and low side undervoltage cannot be disabled while operating.
// R9: four temperature levels are live bits 3,2,1,8 without indicator.
// R10: overheat warning asserts indicator, live warning bit 0, keeps running.
// R11: overheat shutdown latches fault bit 8 and asserts indicator.
// R12: overheat clears only after cooling plus clear command; registers kept.
// R13: watchdog starts disabled and is enabled by writing control bit 3.
// R14: enabled watchdog restarts on each warning status read; expiry faults.
// R15: watchdog fault latches, makes driver safe, pulses power good low 56us.
// R16: watchdog fault asserts indicator, clears enable, sets fault bit 9.
// R17: regulator threshold from bits 1-0, monitor disabled by bit 2.
// R18: regulator low latches, holds power good low while low and 56us min.
// R19: regulator fault clears only when gone, by command or enable pulse.
// R20: clear command clears removed latched faults, then self returns to 0.
// R21: controller clears by enable high, low at least 1us, high again.
// R22: at power up indicator stays low until lockout threshold is passed.
// R23: standby with driver off whenever enable low or a fault exists.
// R24: a fault while operating returns to standby at once.
// R25: indicator is the or of latched faults and present warnings other than temperature levels.
module gdfs_top (
  core_clk,
  nrst,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_byteenable,
  avs_readdata,
  avs_waitrequest,
  main_supply_low_warning,
  gate_driver_supply_lockout,
  main_supply_over_warning,
  pump_relative_overvoltage,
  pump_absolute_overvoltage,
  pump_undervoltage_fault,
  low_side_supply_undervoltage,
  temp_level_one,
  temp_level_two,
  temp_level_three,
  temp_level_four,
  overheat_warning,
  overheat_shutdown,
  regulator_low_raw,
  gate_enable,
  fault_indicator_n,
  power_good_out,
  gate_driver_on,
  pulldown_on,
  regulator_low_threshold_sel,
  operating
);
  input  wire                   core_clk;
  input  wire                   nrst;
  input  wire [`GDFS_ADDR_W-1:0] avs_address;
  input  wire                   avs_read;
  input  wire                   avs_write;
  input  wire [31:0]            avs_writedata;
  input  wire [3:0]             avs_byteenable;
  output reg  [31:0]            avs_readdata;
  output reg                    avs_waitrequest;
  input  wire                   main_supply_low_warning;
  input  wire                   gate_driver_supply_lockout;
  input  wire                   main_supply_over_warning;
  input  wire                   pump_relative_overvoltage;
  input  wire                   pump_absolute_overvoltage;
  input  wire                   pump_undervoltage_fault;
  input  wire                   low_side_supply_undervoltage;
  input  wire                   temp_level_one;
  input  wire                   temp_level_two;
  input  wire                   temp_level_three;
  input  wire                   temp_level_four;
  input  wire                   overheat_warning;
  input  wire                   overheat_shutdown;
  input  wire                   regulator_low_raw;
  input  wire                   gate_enable;
  output reg                    fault_indicator_n;
  output reg                    power_good_out;
  output reg                    gate_driver_on;
  output reg                    pulldown_on;
  output reg  [1:0]             regulator_low_threshold_sel;
  output reg                    operating;

  // ==========================================================
  // input synchronisers
  localparam NIN = 15;
  wire [NIN-1:0] raw_in;
  wire [NIN-1:0] syn;
  assign raw_in = {gate_enable, regulator_low_raw, overheat_shutdown,
                   overheat_warning, temp_level_four, temp_level_three,
                   temp_level_two, temp_level_one,
                   low_side_supply_undervoltage, pump_undervoltage_fault,
                   pump_absolute_overvoltage, pump_relative_overvoltage,
                   main_supply_over_warning, gate_driver_supply_lockout,
                   main_supply_low_warning};
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
      gdfs_sync u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .din      (raw_in[gi]),
        .dout     (syn[gi])
      );
    end
  endgenerate
  wire s_uvfl   = syn[0];
  wire s_lock   = syn[1];
  wire s_ov     = syn[2];
  wire s_prel   = syn[3];
  wire s_pabs   = syn[4];
  wire s_puv    = syn[5];
  wire s_lsuv   = syn[6];
  wire s_t1     = syn[7];
  wire s_t2     = syn[8];
  wire s_t3     = syn[9];
  wire s_t4     = syn[10];
  wire s_otw    = syn[11];
  wire s_overheat_shutdown   = syn[12];
  wire s_reg_lo = syn[13];
  wire s_en     = syn[14];

  // ==========================================================
  // registers and state
  localparam ST_PWRUP = 3'b001;
  localparam ST_STBY  = 3'b010;
  localparam ST_OPER  = 3'b100;
  reg [2:0]  state_ff;
  reg [10:0] ctrl_ff;
  reg [10:0] regcfg_ff;
  reg [10:0] fault_ff;
  reg        en_d_ff;
  reg [15:0] en_low_cnt_ff;
  reg        en_low_ok_ff;
  reg        en_pulse_ff;

  wire watchdog_enable_bit    = ctrl_ff[`GDFS_C_WATCHDOG_ENABLE_BIT];
  wire mon_dis  = regcfg_ff[`GDFS_R_MON_DIS];
  wire reg_lo   = s_reg_lo & ~mon_dis; // R17
  wire wr_lo    = avs_write & avs_byteenable[0];
  wire wr_hi    = avs_write & avs_byteenable[1];
  wire [3:0] idx = avs_address[`GDFS_ADDR_W-1:2];
  wire req      = (avs_read | avs_write) & avs_waitrequest;

  // live conditions per fault bit
  wire [10:0] cond;
  assign cond[`GDFS_F_PUMP_REL] = s_prel; // R5
  assign cond[`GDFS_F_PUMP_ABS] = s_pabs; // R5
  assign cond[`GDFS_F_PUMP_UV]  = s_puv; // R6
  assign cond[3]                = 1'b0;
  assign cond[`GDFS_F_LS_UV]    = s_lsuv; // R7
  assign cond[5]                = 1'b0;
  assign cond[`GDFS_F_REG_UV]   = reg_lo; // R18
  assign cond[7]                = 1'b0;
  assign cond[`GDFS_F_OVERHEAT_SHUTDOWN]     = s_overheat_shutdown; // R11
  assign cond[`GDFS_F_WDOG]     = 1'b0;
  assign cond[`GDFS_F_LOCKOUT]  = s_lock; // R2

  wire [10:0] warn_word = {2'b00, s_t4, s_uvfl, s_ov, 2'b00,
                           s_t1, s_t2, s_t3, s_otw}; // R9
  wire any_warn = s_uvfl | s_ov | s_otw; // R1 R4 R10

  // lockout disable only spares the driver, status bit still latched
  wire [10:0] shut_mask = ctrl_ff[`GDFS_C_UVLO_DIS] ?
                          11'h3ff : 11'h7ff; // R3
  wire shutdown = |(fault_ff & shut_mask); // R23

  // ==========================================================
  // watchdog and power good timers
  localparam [`GDFS_CNT_W-1:0] PG_CYC = `GDFS_PG_CYC;
  // defaults give the long intervals; a bench may shorten them
  parameter [`GDFS_CNT_W-1:0] WD_CYC0 = 24'h0f4240;
  parameter [`GDFS_CNT_W-1:0] WD_CYC1 = 24'h1e8480;
  parameter [`GDFS_CNT_W-1:0] WD_CYC2 = 24'h3d0900;
  parameter [`GDFS_CNT_W-1:0] WD_CYC3 = 24'h7a1200;

  wire st_read  = req & avs_read & (idx == `GDFS_IDX_WARN);
  wire wd_start = req & wr_lo & (idx == `GDFS_IDX_CTRL) &
                  avs_writedata[`GDFS_C_WATCHDOG_ENABLE_BIT] & ~watchdog_enable_bit;
  // the enabling write carries the interval too, so take it from the bus
  wire [1:0] wd_sel = wd_start ?
                      avs_writedata[`GDFS_C_WD_SEL_HI:`GDFS_C_WD_SEL_LO] :
                      ctrl_ff[`GDFS_C_WD_SEL_HI:`GDFS_C_WD_SEL_LO]; // R14
  reg [`GDFS_CNT_W-1:0] wd_val;
  always @* begin
    case (wd_sel)
      2'b00:   wd_val = WD_CYC0;
      2'b01:   wd_val = WD_CYC1;
      2'b10:   wd_val = WD_CYC2;
      default: wd_val = WD_CYC3;
    endcase
  end
  wire wd_busy;
  wire wd_done;
  gdfs_timer u_wd (
    .core_clk (core_clk),
    .nrst     (nrst),
    .load     (wd_start | (st_read & watchdog_enable_bit)), // R14
    .load_val (wd_val),
    .busy     (wd_busy),
    .done     (wd_done)
  );
  wire wd_fire = wd_done & watchdog_enable_bit; // R14

  wire pg_busy;
  gdfs_timer u_pg (
    .core_clk (core_clk),
    .nrst     (nrst),
    .load     (wd_fire | reg_lo), // R15 R18
    .load_val (PG_CYC),
    .busy     (pg_busy),
    .done     ()
  );

  // ==========================================================
  // enable reset pulse detector: high, low >= 1us, high
  localparam [15:0] EN_LOW_CYC = `GDFS_EN_LOW_CYC;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      en_d_ff       <= 1'b0;
      en_low_cnt_ff <= 16'h0000;
      en_low_ok_ff  <= 1'b0;
      en_pulse_ff   <= 1'b0;
    end else begin
      en_d_ff     <= s_en;
      en_pulse_ff <= s_en & ~en_d_ff & en_low_ok_ff; // R19 R21
      if (s_en) begin
        en_low_cnt_ff <= 16'h0000;
        if (en_d_ff)
          en_low_ok_ff <= 1'b0;
      end else if (en_low_cnt_ff != EN_LOW_CYC) begin
        en_low_cnt_ff <= en_low_cnt_ff + 16'h0001;
        // a low time of exactly 1us must already qualify
        if (en_low_cnt_ff == EN_LOW_CYC - 16'h0001)
          en_low_ok_ff <= 1'b1; // R21
      end else begin
        en_low_ok_ff <= 1'b1; // R21
      end
    end
  end

  // ==========================================================
  // fault latches, control registers, bus slave
  wire clr_now = ctrl_ff[`GDFS_C_CLR] | en_pulse_ff; // R20
  wire [10:0] ctrl_mask = `GDFS_CTRL_MASK;
  reg [10:0] nxt_fault;
  reg [10:0] nxt_ctrl;
  reg [10:0] nxt_regcfg;
  reg [31:0] nxt_rdata;
  always @* begin
    nxt_fault  = fault_ff;
    nxt_ctrl   = ctrl_ff;
    nxt_regcfg = regcfg_ff;
    nxt_rdata  = 32'h00000000;
    // clear only those whose condition is gone; set wins
    if (clr_now)
      nxt_fault = fault_ff & cond; // R12 R19 R20
    nxt_fault = nxt_fault | cond; // R2 R5 R6 R7 R11 R18
    if (wd_fire)
      nxt_fault[`GDFS_F_WDOG] = 1'b1; // R16
    if (ctrl_ff[`GDFS_C_CLR])
      nxt_ctrl[`GDFS_C_CLR] = 1'b0; // R20
    if (req & avs_write) begin
      if (idx == `GDFS_IDX_CTRL) begin
        if (wr_lo)
          nxt_ctrl[7:0] = avs_writedata[7:0] & ctrl_mask[7:0];
        if (wr_hi)
          nxt_ctrl[10:8] = avs_writedata[10:8] & ctrl_mask[10:8];
      end
      if (idx == `GDFS_IDX_REG && wr_lo)
        nxt_regcfg = avs_writedata[10:0] & `GDFS_REG_MASK; // R17
    end
    if (wd_fire)
      nxt_ctrl[`GDFS_C_WATCHDOG_ENABLE_BIT] = 1'b0; // R16
    if (req & avs_read) begin
      case (idx)
        `GDFS_IDX_WARN:  nxt_rdata = {21'h000000, warn_word};
        `GDFS_IDX_FAULT: nxt_rdata = {21'h000000, fault_ff};
        `GDFS_IDX_CTRL:  nxt_rdata = {21'h000000, ctrl_ff};
        `GDFS_IDX_REG:   nxt_rdata = {21'h000000, regcfg_ff};
        `GDFS_IDX_MON:   nxt_rdata = {29'h00000000, state_ff};
        default:         nxt_rdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // state machine: power up, standby, operating
  reg [2:0] nxt_state;
  always @* begin
    case (state_ff)
      ST_PWRUP: nxt_state = s_lock ? ST_PWRUP : ST_STBY; // R22
      ST_STBY:  nxt_state = (s_en & ~shutdown) ? ST_OPER : ST_STBY; // R23
      ST_OPER:  nxt_state = (~s_en | shutdown) ? ST_STBY : ST_OPER; // R24
      default:  nxt_state = ST_PWRUP;
    endcase
  end

  // pump and low side undervoltage have no disable bit; the shutdown mask
  // keeps both bits in every state and every control setting
  wire uv_armed = shut_mask[`GDFS_F_PUMP_UV] &
                  shut_mask[`GDFS_F_LS_UV]; // R8

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff                    <= ST_PWRUP;
      ctrl_ff                     <= `GDFS_CTRL_RST; // R13
      regcfg_ff                   <= `GDFS_REG_RST;
      fault_ff                    <= 11'h000;
      avs_readdata                <= 32'h00000000;
      avs_waitrequest             <= 1'b1;
      fault_indicator_n           <= 1'b0;
      power_good_out              <= 1'b0;
      gate_driver_on              <= 1'b0;
      pulldown_on                 <= 1'b1;
      regulator_low_threshold_sel <= 2'b00;
      operating                   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      ctrl_ff   <= nxt_ctrl;
      regcfg_ff <= nxt_regcfg;
      fault_ff  <= nxt_fault;
      // one wait cycle per access, then answer
      avs_waitrequest <= ~req;
      if (req)
        avs_readdata <= nxt_rdata;
      fault_indicator_n <= (state_ff != ST_PWRUP) &
                           ~(|nxt_fault) & ~any_warn; // R22 R25 R1 R4 R10
      power_good_out <= ~(pg_busy | reg_lo | wd_fire); // R15 R18
      gate_driver_on <= (nxt_state == ST_OPER) & ~(|(nxt_fault & shut_mask))
                        & uv_armed; // R23 R24 R8
      pulldown_on    <= ~((nxt_state == ST_OPER) &
                        ~(|(nxt_fault & shut_mask))); // R23
      regulator_low_threshold_sel <=
        regcfg_ff[`GDFS_R_LVL_HI:`GDFS_R_LVL_LO]; // R17
      operating <= (nxt_state == ST_OPER);
    end
  end
endmodule // gdfs_top

// ==== dv/gdfs_top_properties.sv ====
// gdfs_top_properties.sv: port checker for the supervisor
`timescale 1ns/1ps
module gdfs_chk (
  input wire core_clk,
  input wire nrst,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire main_supply_low_warning,
  input wire pump_undervoltage_fault,
  input wire low_side_supply_undervoltage,
  input wire overheat_shutdown,
  input wire gate_enable,
  input wire fault_indicator_n,
  input wire power_good_out,
  input wire gate_driver_on,
  input wire pulldown_on,
  input wire operating
);
  // ==========================================
  // power good low-time counter
  reg [15:0] pg_lo_ff;
  reg        armed_ff;
  // armed skips the rise right after reset, which is not a pulse end
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pg_lo_ff <= 16'h0000;
      armed_ff <= 1'b0;
    end else begin
      armed_ff <= armed_ff | power_good_out;
      if (power_good_out || !armed_ff) pg_lo_ff <= 16'h0000;
      else if (pg_lo_ff != 16'hffff) pg_lo_ff <= pg_lo_ff + 16'h0001;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ==========================================
  // properties
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus request not answered");
  single_ack_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  warn_indicator_a: assert property ($rose(main_supply_low_warning)
    |-> ##[2:6] !fault_indicator_n) else $error("warning not shown");
  pump_stop_a: assert property ($rose(pump_undervoltage_fault)
    |-> ##[2:6] (!gate_driver_on && !fault_indicator_n))
    else $error("pump fault did not stop driver");
  low_side_stop_a: assert property ($rose(low_side_supply_undervoltage)
    |-> ##[2:6] (!gate_driver_on && !fault_indicator_n))
    else $error("low side fault did not stop driver");
  heat_stop_a: assert property ($rose(overheat_shutdown)
    |-> ##[2:6] (!gate_driver_on && !fault_indicator_n))
    else $error("overheat did not stop driver");
  pulldown_inv_a: assert property (pulldown_on == !gate_driver_on)
    else $error("pulldown not inverse of driver");
  enable_low_a: assert property ((!gate_enable) [*5]
    |-> (!operating && !gate_driver_on)) else $error("running without enable");
  pg_min_low_a: assert property ($rose(power_good_out) && armed_ff
    |-> pg_lo_ff >= 16'h2bc0) else $error("power good pulse too short");
endmodule // gdfs_chk
bind gdfs_top gdfs_chk gdfs_chk_inst (
  .core_clk(core_clk), .nrst(nrst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .main_supply_low_warning(main_supply_low_warning),
  .pump_undervoltage_fault(pump_undervoltage_fault),
  .low_side_supply_undervoltage(low_side_supply_undervoltage),
  .overheat_shutdown(overheat_shutdown), .gate_enable(gate_enable),
  .fault_indicator_n(fault_indicator_n), .power_good_out(power_good_out),
  .gate_driver_on(gate_driver_on), .pulldown_on(pulldown_on),
  .operating(operating)
);

// ==== dv/gdfs_mcu.sv ====
// gdfs_mcu.sv: controller model driving the gate enable pin
`timescale 1ns/1ps
module gdfs_mcu #(
  parameter LOW_CYC = 200
) (
  input  wire core_clk,
  input  wire en_lvl,
  input  wire pulse_go,
  output reg  gate_enable
);
  // ==========================================
  // enable pin with reset pulse
  reg [15:0] low_ff;
  initial low_ff = 16'h0000;
  initial gate_enable = 1'b0;
  always @(posedge core_clk) begin
    if (pulse_go) low_ff <= LOW_CYC[15:0];
    else if (low_ff != 16'h0000) low_ff <= low_ff - 16'h0001;
    gate_enable <= en_lvl && (low_ff == 16'h0000) && !pulse_go;
  end
endmodule // gdfs_mcu

// ==== dv/tb_gdfs_top.sv ====
// tb_gdfs_top.sv: self-checking bench for the supervisor
`timescale 1ns/1ps
`include "gdfs_defs.vh"
module tb_gdfs_top;
  reg         core_clk = 1'b0;
  reg         nrst = 1'b0;
  reg  [5:0]  adr = 6'h00;
  reg         rd = 1'b0;
  reg         wr = 1'b0;
  reg  [31:0] wd = 32'h0;
  reg  [13:0] src = 14'h0;
  reg         en_lvl = 1'b0;
  reg         en_go = 1'b0;
  wire [31:0] rdata;
  wire [1:0]  sel;
  wire        wait_r, ind_n, pg, drv_on, pd_on, op, gate_en;
  integer     failures = 0;
  integer     checks_done = 0;
  integer     seed = 32'ha8c2;
  integer     i;
  integer     wn;
  reg  [31:0] v;
  reg  [1:0]  ws;
  always #2.5 core_clk = ~core_clk;
  gdfs_mcu gdfs_mcu_inst (.core_clk(core_clk), .en_lvl(en_lvl),
    .pulse_go(en_go), .gate_enable(gate_en));
  gdfs_top #(.WD_CYC0(24'h00003c), .WD_CYC1(24'h000078),
    .WD_CYC2(24'h0000f0), .WD_CYC3(24'h0001e0)) gdfs_top_inst (
    .core_clk(core_clk), .nrst(nrst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
    .avs_readdata(rdata), .avs_waitrequest(wait_r),
    .main_supply_low_warning(src[0]), .gate_driver_supply_lockout(src[1]),
    .main_supply_over_warning(src[2]), .pump_relative_overvoltage(src[3]),
    .pump_absolute_overvoltage(src[4]), .pump_undervoltage_fault(src[5]),
    .low_side_supply_undervoltage(src[6]), .temp_level_one(src[7]),
    .temp_level_two(src[8]), .temp_level_three(src[9]),
    .temp_level_four(src[10]), .overheat_warning(src[11]),
    .overheat_shutdown(src[12]), .regulator_low_raw(src[13]),
    .gate_enable(gate_en), .fault_indicator_n(ind_n), .power_good_out(pg),
    .gate_driver_on(drv_on), .pulldown_on(pd_on),
    .regulator_low_threshold_sel(sel), .operating(op));
  // ==========================================
  // expected status bit of each monitor input
  function [31:0] bitof(input integer k);
    case (k)
      0: bitof = 1 << `GDFS_W_UVFL;
      1: bitof = 1 << `GDFS_F_LOCKOUT;
      2: bitof = 1 << `GDFS_W_OV;
      3: bitof = 1 << `GDFS_F_PUMP_REL;
      4: bitof = 1 << `GDFS_F_PUMP_ABS;
      5: bitof = 1 << `GDFS_F_PUMP_UV;
      6: bitof = 1 << `GDFS_F_LS_UV;
      7: bitof = 1 << `GDFS_W_TEMP1;
      8: bitof = 1 << `GDFS_W_TEMP2;
      9: bitof = 1 << `GDFS_W_TEMP3;
      10: bitof = 1 << `GDFS_W_TEMP4;
      11: bitof = 1 << `GDFS_W_OTW;
      12: bitof = 1 << `GDFS_F_OVERHEAT_SHUTDOWN;
      default: bitof = 1 << `GDFS_F_REG_UV;
    endcase
  endfunction
  function wrn(input integer k);
    wrn = (k == 0) || (k == 2) || (k > 6 && k < 12);
  endfunction
  // ==========================================
  // tasks
  task conclude;
    begin
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  // master holds the request until waitrequest is sampled low
  task bus(input w, input [5:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge core_clk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      n = 0;
      @(posedge core_clk);
      while (wait_r !== 1'b0 && n < 20) begin
        @(posedge core_clk);
        n = n + 1;
      end
      v = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n == 20) begin
        failures = failures + 1;
        conclude;
      end
    end
  endtask
  task wait_pg;
    integer n;
    begin
      n = 0;
      while (pg !== 1'b1 && n < 12000) begin
        @(posedge core_clk);
        n = n + 1;
      end
      if (n == 12000) begin
        failures = failures + 1;
        conclude;
      end
    end
  endtask
  task pulse_en;
    begin
      @(posedge core_clk);
      en_lvl <= 1'b1;
      en_go <= 1'b1;
      @(posedge core_clk);
      en_go <= 1'b0;
      wt(215);
    end
  endtask
  task clear;
    begin
      bus(1, 6'h24, 32'h2);
      wt(2);
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    wt(2);
    chk(ind_n, 0);
    chk(pd_on, 1);
    nrst <= 1'b1;
    wt(6);
    bus(0, 6'h3c, 0);
    chk(v, 2);
    bus(0, 6'h24, 0);
    chk(v, `GDFS_CTRL_RST);
    bus(1, 6'h10, 32'h7ff);
    bus(0, 6'h10, 0);
    chk(v, 0);
    ws = $random(seed);
    bus(1, 6'h2c, {30'h0, ws});
    wt(2);
    chk(sel, ws);
    for (i = 0; i < 12; i = i + 1) if (wrn(i)) begin
      src[i] <= 1'b1;
      wt(8);
      bus(0, 6'h04, 0);
      chk(v, bitof(i));
      chk(ind_n, i > 6 && i < 11);
      src[i] <= 1'b0;
      wt(8);
      chk(ind_n, 1);
    end
    for (i = 1; i < 13; i = i + 1) if (!wrn(i)) begin
      pulse_en;
      chk(op, 1);
      src[i] <= 1'b1;
      wt(8);
      chk(drv_on, 0);
      clear;
      bus(0, 6'h0c, 0);
      chk(v, bitof(i));
      src[i] <= 1'b0;
      wt(8);
      chk(ind_n, 0);
      clear;
      bus(0, 6'h0c, 0);
      chk(v, 0);
      bus(0, 6'h24, 0);
      chk(v, 0);
    end
    bus(1, 6'h24, 32'h200);
    pulse_en;
    src[1] <= 1'b1;
    wt(8);
    chk(drv_on, 1);
    bus(0, 6'h0c, 0);
    chk(v, bitof(1));
    src[1] <= 1'b0;
    wt(4);
    clear;
    src[13] <= 1'b1;
    wt(8);
    chk(pg, 0);
    bus(0, 6'h0c, 0);
    chk(v, bitof(13));
    wt(100);
    chk(pg, 0);
    src[13] <= 1'b0;
    wait_pg;
    pulse_en;
    bus(0, 6'h0c, 0);
    chk(v, 0);
    bus(1, 6'h2c, 32'h4);
    src[13] <= 1'b1;
    wt(8);
    bus(0, 6'h0c, 0);
    chk(v, 0);
    chk(pg, 1);
    src[13] <= 1'b0;
    ws = $random(seed);
    bus(1, 6'h24, 32'h8 | (ws << 5));
    for (i = 0; i < 8; i = i + 1) begin
      wt(40);
      bus(0, 6'h04, 0);
      bus(0, 6'h0c, 0);
      chk(v, 0);
    end
    // expiry must follow the interval chosen with the enabling write
    wn = 0;
    while (pg !== 1'b0 && wn < 600) begin
      @(posedge core_clk);
      wn = wn + 1;
    end
    chk(wn >= (60 << ws) - 8 && wn <= (60 << ws), 1);
    chk(pg, 0);
    chk(ind_n, 0);
    bus(0, 6'h0c, 0);
    chk(v, 1 << `GDFS_F_WDOG);
    bus(0, 6'h24, 0);
    chk(v, ws << 5);
    wait_pg;
    conclude;
  end
endmodule // tb_gdfs_top
